// ===== bench/dac_monitor.sv
module dac_monitor
	import dac_ctrl_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic strap_config_mode,
	input wire logic power_down_pin,
	input wire logic format_data_oe_n,
	input wire logic device_powered_down,
	input wire logic [SAMPLE_W-1:0] chan_a_true_output,
	input wire logic [SAMPLE_W-1:0] chan_a_comp_output,
	input wire logic [SAMPLE_W-1:0] chan_b_true_output,
	input wire logic [SAMPLE_W-1:0] chan_b_comp_output
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==================================================================
	// properties
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// pins cross a synchroniser, so hold them well past its depth
	sequence pin_pd_held;
		(strap_config_mode && power_down_pin && clk_en) [*8];
	endsequence
	sequence pin_mode_held;
		(strap_config_mode && clk_en) [*8];
	endsequence
	sequence select_high_held;
		(power_down_pin && clk_en) [*8];
	endsequence
	AST_OKAY: assert property (hresp == 1'b0)
		else $error("hresp not okay");
	AST_READY: assert property (hreadyout == clk_en)
		else $error("hreadyout differs from clk_en");
	AST_FREEZE: assert property (!clk_en |=>
		$stable(chan_a_true_output) && $stable(device_powered_down))
		else $error("state moved while frozen");
	AST_COMP_A: assert property (!device_powered_down |->
		chan_a_comp_output == ~chan_a_true_output)
		else $error("channel a comp not inverse");
	AST_COMP_B: assert property (!device_powered_down |->
		chan_b_comp_output == ~chan_b_true_output)
		else $error("channel b comp not inverse");
	AST_PD_ZERO: assert property (device_powered_down |->
		(chan_a_true_output | chan_a_comp_output | chan_b_true_output
		| chan_b_comp_output) == 8'h00)
		else $error("outputs live while powered down");
	AST_PIN_PD: assert property (pin_pd_held |-> device_powered_down)
		else $error("power down pin ignored");
	AST_PIN_QUIET: assert property (pin_mode_held |->
		format_data_oe_n)
		else $error("data pin driven in pin mode");
	AST_SEL_QUIET: assert property (select_high_held |->
		format_data_oe_n)
		else $error("data pin driven while deselected");
endmodule

bind dual_dac_pin_mode_control dac_monitor i_dac_monitor (.hclk, .hresetn,
	.clk_en, .hreadyout, .hresp, .strap_config_mode, .power_down_pin,
	.format_data_oe_n, .device_powered_down, .chan_a_true_output,
	.chan_a_comp_output, .chan_b_true_output, .chan_b_comp_output);

// ===== bench/dual_dac_pin_mode_control_tb.sv
module dual_dac_pin_mode_control_tb
	import dac_ctrl_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic clk_en = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic strap_config_mode = 1'b1;
	logic retime_phase_select = 1'b0;
	logic power_down_pin = 1'b0;
	logic host_en = 1'b1;
	logic host_bit = 1'b0;
	logic send = 1'b0;
	logic [7:0] word_a = 8'h00;
	logic [7:0] word_b = 8'h00;
	logic format_data_in, hreadyout, hresp, format_data_out, format_data_oe_n;
	logic device_powered_down, data_qualify_clock, sampling_clock, done;
	logic [31:0] hrdata, r;
	logic [7:0] sample_data, chan_a_true_output, chan_a_comp_output;
	logic [7:0] chan_b_true_output, chan_b_comp_output, sr;
	logic [7:0] ta [3] = '{8'hFF, 8'h00, 8'h80};
	logic [7:0] tb_ [3] = '{8'h00, 8'hFF, 8'h01};
	int fail_count = 0;
	int n_tests = 0;
	int cyc = 0;
	// released data line shows the inverse of the last host bit
	assign format_data_in = host_en ? host_bit :
		(format_data_oe_n ? ~host_bit : format_data_out);
	dual_dac_pin_mode_control i_dual_dac_pin_mode_control (
		.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.strap_config_mode, .retime_phase_select, .format_data_in,
		.format_data_out, .format_data_oe_n, .power_down_pin,
		.data_qualify_clock, .sampling_clock, .sample_data,
		.chan_a_true_output, .chan_a_comp_output, .chan_b_true_output,
		.chan_b_comp_output, .device_powered_down);
	sample_host i_sample_host (.hclk, .send, .word_a, .word_b,
		.data_qualify_clock, .sampling_clock, .sample_data, .done);
	always #25 hclk = ~hclk;
	// ==================================================================
	// tasks
	task wt(input int n);
		repeat (n) @(posedge hclk);
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, r);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, r);
		chk("read data", e, r);
	endtask
	task pair(input logic [7:0] a, input logic [7:0] b);
		word_a <= a;
		word_b <= b;
		send <= 1'b1;
		@(posedge hclk);
		send <= 1'b0;
		do @(posedge hclk); while (done !== 1'b1);
	endtask
	task ser(input logic [15:0] f, output logic [7:0] q);
		for (int i = 15; i >= 0; i--) begin
			host_en <= !f[15] || (i > 7);
			host_bit <= f[i];
			wt(8);
			if (i < 8) q[i] = format_data_in;
			retime_phase_select <= 1'b1;
			wt(8);
			retime_phase_select <= 1'b0;
		end
		chk("data released", 32'h1, 32'(format_data_oe_n));
		host_en <= 1'b1;
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			tally_and_finish;
		end
	end
	// ==================================================================
	// tests
	initial begin
		wt(16);
		hresetn <= 1'b1;
		wt(16);
		rd(ADDR_CTRL, CTRL_RESET);
		rd(8'h20, 32'h0);
		wr(ADDR_CTRL, 32'h0);
		rd(ADDR_CTRL, 32'h0);
		wr(ADDR_CTRL, CTRL_RESET);
		clk_en <= 1'b0;
		wt(2);
		chk("hreadyout", 32'h0, 32'(hreadyout));
		clk_en <= 1'b1;
		wt(1);
		bus(1'b0, ADDR_STATUS, 32'h0, r);
		chk("serial flag", 32'h0, 32'(r[ST_SERIAL_BIT]));
		$display("test registers done");
		for (int i = 0; i < 3; i++) begin
			pair(ta[i], tb_[i]);
			chk("code a", 32'(ta[i]), 32'(chan_a_true_output));
			chk("code b", 32'(tb_[i]), 32'(chan_b_true_output));
			chk("comp a", {24'h0, ~ta[i]}, 32'(chan_a_comp_output));
		end
		host_bit <= 1'b1;
		wt(16);
		pair(8'h00, 8'h7F);
		chk("twos b", 32'hFF, 32'(chan_b_true_output));
		rd(ADDR_CODE_A, 32'h80);
		rd(ADDR_CODE_B, 32'hFF);
		bus(1'b0, ADDR_STATUS, 32'h0, r);
		chk("twos flag", 32'h1, 32'(r[ST_TWOS_BIT]));
		$display("test formats done");
		wr(ADDR_CTRL, 32'h0);
		pair(8'h11, 8'h22);
		chk("path off", 32'h80, 32'(chan_a_true_output));
		wr(ADDR_CTRL, CTRL_RESET);
		power_down_pin <= 1'b1;
		wt(16);
		chk("pd flag", 32'h1, 32'(device_powered_down));
		bus(1'b0, ADDR_STATUS, 32'h0, r);
		chk("pd status", 32'h1, 32'(r[ST_PD_BIT]));
		pair(8'h33, 8'h44);
		power_down_pin <= 1'b0;
		wt(16);
		chk("after pd", 32'h80, 32'(chan_a_true_output));
		$display("test power down done");
		host_bit <= 1'b0;
		retime_phase_select <= 1'b1;
		wt(16);
		bus(1'b0, ADDR_STATUS, 32'h0, r);
		chk("phase", 32'h1, 32'(r[ST_PHASE_BIT]));
		pair(8'h5A, 8'hA5);
		chk("phase code", 32'h5A, 32'(chan_a_true_output));
		$display("test phase done");
		ser(16'h8000, sr);
		chk("pin quiet", 32'hFF, 32'(sr));
		strap_config_mode <= 1'b0;
		retime_phase_select <= 1'b0;
		power_down_pin <= 1'b1;
		wt(16);
		bus(1'b0, ADDR_STATUS, 32'h0, r);
		chk("serial flag", 32'h1, 32'(r[ST_SERIAL_BIT]));
		power_down_pin <= 1'b0;
		wt(8);
		ser(16'h0003, sr);
		power_down_pin <= 1'b1;
		wt(8);
		rd(ADDR_SER_CFG, 32'h3);
		chk("serial pd", 32'h1, 32'(device_powered_down));
		power_down_pin <= 1'b0;
		wt(8);
		ser(16'h8000, sr);
		power_down_pin <= 1'b1;
		chk("serial read", 32'h3, 32'(sr));
		ser(16'h0005, sr);
		rd(ADDR_SER_CFG, 32'h3);
		strap_config_mode <= 1'b1;
		wt(8);
		strap_config_mode <= 1'b0;
		wt(16);
		rd(ADDR_SER_CFG, 32'(SER_CFG_RESET));
		$display("test serial done");
		tally_and_finish;
	end
endmodule

// ===== bench/sample_host.sv
module sample_host
	import dac_ctrl_pkg::*;
(
	input wire logic hclk,
	input wire logic send,
	input wire logic [SAMPLE_W-1:0] word_a,
	input wire logic [SAMPLE_W-1:0] word_b,
	output logic data_qualify_clock,
	output logic sampling_clock,
	output logic [SAMPLE_W-1:0] sample_data,
	output logic done
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [6:0] cnt_q = 7'h00;
	logic busy_q = 1'b0;
	initial begin
		data_qualify_clock = 1'b0;
		sampling_clock = 1'b0;
		sample_data = 8'h00;
		done = 1'b0;
	end
	// ==================================================================
	// one pair: words held ten cycles around each data clock edge
	always @(posedge hclk) begin
		done <= 1'b0;
		if (send && !busy_q) begin
			busy_q <= 1'b1;
			cnt_q <= 7'h00;
		end else if (busy_q) begin
			cnt_q <= cnt_q + 7'h01;
			case (cnt_q)
				7'h00: sample_data <= word_a;
				7'h0A: data_qualify_clock <= 1'b1;
				7'h14: sample_data <= word_b;
				7'h1E: data_qualify_clock <= 1'b0;
				// released bus shows garbage, never the last word
				7'h28: sample_data <= ~word_b;
				7'h30: sampling_clock <= 1'b1;
				7'h3A: sampling_clock <= 1'b0;
				7'h50: begin
					busy_q <= 1'b0;
					done <= 1'b1;
				end
				default: ;
			endcase
		end
	end
endmodule

// ===== include/dac_ctrl_pkg.sv
package dac_ctrl_pkg;

	// ==================================================================
	// sample path
	localparam int SAMPLE_W = 8;
	localparam int MSB_BIT = SAMPLE_W - 1;

	// ==================================================================
	// pin synchroniser bundle, one slot per input from outside hclk
	localparam int IDX_STRAP = 0;
	localparam int IDX_SHARED_CLK = 1;
	localparam int IDX_SHARED_DATA = 2;
	localparam int IDX_SHARED_SEL = 3;
	localparam int IDX_DQ_CLK = 4;
	localparam int IDX_SMP_CLK = 5;
	localparam int IDX_DATA_LSB = 6;
	localparam int SYNC_W = IDX_DATA_LSB + SAMPLE_W;

	// ==================================================================
	// bus register map (byte addresses)
	localparam int ADDR_W = 8;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_CODE_A = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_CODE_B = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_SER_CFG = 8'h10;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	localparam int CTRL_PATH_EN_BIT = 0;
	localparam int ST_SERIAL_BIT = 0;
	localparam int ST_PD_BIT = 1;
	localparam int ST_TWOS_BIT = 2;
	localparam int ST_PHASE_BIT = 3;
	localparam int ST_BUSY_BIT = 4;
	localparam int ST_PAIR_BIT = 5;

	// ==================================================================
	// serial configuration port
	localparam int SER_CNT_W = 4;
	localparam logic [SER_CNT_W-1:0] SER_LAST_BIT = 4'hF;
	localparam logic [SER_CNT_W-1:0] SER_INSTR_LAST = 4'h7;
	localparam int SER_ADDR_W = 5;
	localparam logic [SER_ADDR_W-1:0] SER_CFG_ADDR = 5'h00;
	localparam logic [SAMPLE_W-1:0] SER_CFG_RESET = 8'h00;
	localparam int INSTR_RW_BIT = 7;
	localparam int CFG_TWOS_BIT = 0;
	localparam int CFG_PD_BIT = 1;
	localparam int CFG_PHASE_BIT = 2;

endpackage

// ===== rtl/cfg_serial_port.sv
module cfg_serial_port
	import dac_ctrl_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic regs_clear,
	input wire logic port_enable,
	input wire logic sclk_lvl,
	input wire logic sel_n_lvl,
	input wire logic sdio_lvl,
	output logic sdio_out,
	output logic sdio_oe_n,
	output logic [SAMPLE_W-1:0] cfg_reg,
	output logic busy
);

	typedef enum logic {SP_IDLE, SP_SHIFT} sp_state_e;

	sp_state_e state_q, state_d;
	logic [SER_CNT_W-1:0] cnt_q, cnt_d;
	logic [SAMPLE_W-1:0] shift_q, shift_d;
	logic [SAMPLE_W-1:0] tx_q, tx_d;
	logic [SAMPLE_W-1:0] cfg_q, cfg_d;
	logic is_read_q, is_read_d;
	logic [SER_ADDR_W-1:0] addr_q, addr_d;
	logic out_q, out_d;
	logic oe_n_q, oe_n_d;
	logic sclk_prev_q;
	logic active, rise, fall;
	logic [SAMPLE_W-1:0] word_in;

	// ==================================================================
	// frame decode
	assign active = port_enable && !sel_n_lvl;
	assign rise = sclk_lvl && !sclk_prev_q;
	assign fall = !sclk_lvl && sclk_prev_q;
	assign word_in = {shift_q[SAMPLE_W-2:0], sdio_lvl};

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		shift_d = shift_q;
		tx_d = tx_q;
		cfg_d = cfg_q;
		is_read_d = is_read_q;
		addr_d = addr_q;
		out_d = out_q;
		oe_n_d = oe_n_q;
		if (!active) begin
			state_d = SP_IDLE;
			cnt_d = '0;
			oe_n_d = 1'b1;
		end else begin
			state_d = SP_SHIFT;
			if (rise) begin
				shift_d = word_in;
				cnt_d = cnt_q + 4'h1;
				if (cnt_q == SER_INSTR_LAST) begin
					is_read_d = word_in[INSTR_RW_BIT];
					addr_d = word_in[SER_ADDR_W-1:0];
					tx_d = (word_in[SER_ADDR_W-1:0] == SER_CFG_ADDR) ?
						cfg_q : '0;
				end
				if (cnt_q == SER_LAST_BIT) begin
					cnt_d = '0;
					// let go at the last rise, before the host drives again
					oe_n_d = 1'b1;
					if (!is_read_q && addr_q == SER_CFG_ADDR) begin
						cfg_d = word_in;
					end
				end
			end
			// read data leaves on the falling edge so it is stable at rise
			if (fall) begin
				if (is_read_q && cnt_q > SER_INSTR_LAST) begin
					out_d = tx_q[MSB_BIT];
					tx_d = {tx_q[SAMPLE_W-2:0], 1'b0};
					oe_n_d = 1'b0;
				end else begin
					oe_n_d = 1'b1;
				end
			end
		end
		if (regs_clear) begin
			cfg_d = SER_CFG_RESET;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= SP_IDLE;
			cnt_q <= '0;
			shift_q <= '0;
			tx_q <= '0;
			cfg_q <= SER_CFG_RESET;
			is_read_q <= 1'b0;
			addr_q <= '0;
			out_q <= 1'b0;
			oe_n_q <= 1'b1;
			sclk_prev_q <= 1'b0;
		end else if (clk_en) begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			shift_q <= shift_d;
			tx_q <= tx_d;
			cfg_q <= cfg_d;
			is_read_q <= is_read_d;
			addr_q <= addr_d;
			out_q <= out_d;
			oe_n_q <= oe_n_d;
			sclk_prev_q <= sclk_lvl;
		end
	end

	assign sdio_out = out_q;
	assign sdio_oe_n = oe_n_q;
	assign cfg_reg = cfg_q;
	assign busy = (state_q == SP_SHIFT);

endmodule

// ===== rtl/dual_dac_pin_mode_control.sv
// Notes on behaviour
// - a low mode strap selects serial configuration, a high one pin mode.
// - a high pulse on the mode strap returns the serial registers to reset.
// - in serial mode the shared clock pin clocks the configuration port.
// - in serial mode the data pin is one line that each side drives in turn.
// - in serial mode the port answers only while the shared select is low.
// - in serial mode the phase register bit sets the retiming phase to the sample clock.
// - otherwise a rising edge on the phase pin arms the opposite retime edge.
// - in pin mode the format pin picks straight binary or twos complement.
// - in pin mode a high power-down pin stops the path, not the serial port.
// - true outputs carry the code, complementary outputs its inverse.
// - sample words are eight bits with the top input as the msb.
// - words are taken on the data clock, then retimed to the sample clock.
module dual_dac_pin_mode_control
	import dac_ctrl_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic strap_config_mode,
	input wire logic retime_phase_select,
	input wire logic format_data_in,
	output logic format_data_out,
	output logic format_data_oe_n,
	input wire logic power_down_pin,
	input wire logic data_qualify_clock,
	input wire logic sampling_clock,
	input wire logic [SAMPLE_W-1:0] sample_data,
	output logic [SAMPLE_W-1:0] chan_a_true_output,
	output logic [SAMPLE_W-1:0] chan_a_comp_output,
	output logic [SAMPLE_W-1:0] chan_b_true_output,
	output logic [SAMPLE_W-1:0] chan_b_comp_output,
	output logic device_powered_down
);

	// ==================================================================
	// pin synchronisers: three stages, a change counts once 2 and 3 agree
	logic [SYNC_W-1:0] pins_raw;
	logic [SYNC_W-1:0] s1_q, s2_q, s3_q;
	logic [SYNC_W-1:0] lvl_q, lvl_d;

	assign pins_raw = {sample_data, sampling_clock, data_qualify_clock,
		power_down_pin, format_data_in, retime_phase_select,
		strap_config_mode};

	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi++) begin : g_filt
			assign lvl_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : lvl_q[gi];
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			lvl_q <= '0;
		end else if (clk_en) begin
			s1_q <= pins_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= lvl_d;
		end
	end

	// ==================================================================
	// edge detection on filtered levels
	logic dq_prev_q, smp_prev_q, ph_prev_q, mode_prev_q;
	logic serial_mode, pin_mode, mode_change;
	logic dq_rise, dq_fall, smp_rise, smp_fall, ph_rise;
	logic [SAMPLE_W-1:0] data_lvl;

	assign serial_mode = !lvl_q[IDX_STRAP];
	assign pin_mode = lvl_q[IDX_STRAP];
	assign mode_change = pin_mode != mode_prev_q;
	assign data_lvl = lvl_q[IDX_DATA_LSB +: SAMPLE_W];
	assign dq_rise = lvl_q[IDX_DQ_CLK] && !dq_prev_q;
	assign dq_fall = !lvl_q[IDX_DQ_CLK] && dq_prev_q;
	assign smp_rise = lvl_q[IDX_SMP_CLK] && !smp_prev_q;
	assign smp_fall = !lvl_q[IDX_SMP_CLK] && smp_prev_q;
	assign ph_rise = lvl_q[IDX_SHARED_CLK] && !ph_prev_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dq_prev_q <= 1'b0;
			smp_prev_q <= 1'b0;
			ph_prev_q <= 1'b0;
			mode_prev_q <= 1'b0;
		end else if (clk_en) begin
			dq_prev_q <= lvl_q[IDX_DQ_CLK];
			smp_prev_q <= lvl_q[IDX_SMP_CLK];
			ph_prev_q <= lvl_q[IDX_SHARED_CLK];
			mode_prev_q <= pin_mode;
		end
	end

	// ==================================================================
	// serial configuration port
	logic [SAMPLE_W-1:0] ser_cfg;
	logic ser_busy;

	cfg_serial_port u_serial (
		.hclk(hclk),
		.hresetn(hresetn),
		.clk_en(clk_en),
		.regs_clear(lvl_q[IDX_STRAP]),
		.port_enable(serial_mode),
		.sclk_lvl(lvl_q[IDX_SHARED_CLK]),
		.sel_n_lvl(lvl_q[IDX_SHARED_SEL]),
		.sdio_lvl(lvl_q[IDX_SHARED_DATA]),
		.sdio_out(format_data_out),
		.sdio_oe_n(format_data_oe_n),
		.cfg_reg(ser_cfg),
		.busy(ser_busy)
	);

	// ==================================================================
	// effective configuration, from pins or from the serial register
	logic twos_eff, pd_eff;
	logic phase_q, phase_d;

	assign twos_eff = pin_mode ? lvl_q[IDX_SHARED_DATA] :
		ser_cfg[CFG_TWOS_BIT];
	assign pd_eff = pin_mode ? lvl_q[IDX_SHARED_SEL] :
		ser_cfg[CFG_PD_BIT];

	// a held-low phase pin keeps the rising retime edge; the armed phase
	// sticks until the mode changes, so glitches after arming are harmless
	always_comb begin
		phase_d = phase_q;
		if (mode_change) begin
			phase_d = 1'b0;
		end else if (serial_mode) begin
			phase_d = ser_cfg[CFG_PHASE_BIT];
		end else if (ph_rise) begin
			phase_d = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_q <= 1'b0;
		end else if (clk_en) begin
			phase_q <= phase_d;
		end
	end

	// ==================================================================
	// capture on the data clock, a on rise and b on fall
	logic [31:0] ctrl_q, ctrl_d;
	logic path_en;
	logic [SAMPLE_W-1:0] cap_a_q, cap_a_d, cap_b_q, cap_b_d;
	logic pair_q, pair_d;
	logic retime_stb;

	assign path_en = ctrl_q[CTRL_PATH_EN_BIT] && !pd_eff;
	assign retime_stb = phase_q ? smp_fall : smp_rise;

	always_comb begin
		cap_a_d = cap_a_q;
		cap_b_d = cap_b_q;
		pair_d = pair_q;
		if (retime_stb) begin
			pair_d = 1'b0;
		end
		if (path_en && dq_rise) begin
			cap_a_d = data_lvl;
		end
		if (path_en && dq_fall) begin
			cap_b_d = data_lvl;
			pair_d = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cap_a_q <= '0;
			cap_b_q <= '0;
			pair_q <= 1'b0;
		end else if (clk_en) begin
			cap_a_q <= cap_a_d;
			cap_b_q <= cap_b_d;
			pair_q <= pair_d;
		end
	end

	// ==================================================================
	// retime to the sampling clock and convert format
	function automatic logic [SAMPLE_W-1:0] to_offset(
		input logic [SAMPLE_W-1:0] w, input logic twos);
		to_offset = twos ? {~w[MSB_BIT], w[SAMPLE_W-2:0]} : w;
	endfunction

	logic [SAMPLE_W-1:0] code_a_q, code_a_d, code_b_q, code_b_d;
	logic pd_out_q, pd_out_d;

	always_comb begin
		code_a_d = code_a_q;
		code_b_d = code_b_q;
		pd_out_d = pd_eff;
		if (retime_stb && pair_q && path_en) begin
			code_a_d = to_offset(cap_a_q, twos_eff);
			code_b_d = to_offset(cap_b_q, twos_eff);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			code_a_q <= '0;
			code_b_q <= '0;
			pd_out_q <= 1'b0;
		end else if (clk_en) begin
			code_a_q <= code_a_d;
			code_b_q <= code_b_d;
			pd_out_q <= pd_out_d;
		end
	end

	// powered down, no output carries current
	assign chan_a_true_output = pd_out_q ? '0 : code_a_q;
	assign chan_a_comp_output = pd_out_q ? '0 : ~code_a_q;
	assign chan_b_true_output = pd_out_q ? '0 : code_b_q;
	assign chan_b_comp_output = pd_out_q ? '0 : ~code_b_q;
	assign device_powered_down = pd_out_q;

	// ==================================================================
	// bus slave, zero wait states; read data is taken in the address phase
	logic wr_pend_q, wr_pend_d;
	logic [ADDR_W-1:0] wr_addr_q, wr_addr_d;
	logic [31:0] rdata_q, rdata_d;
	logic [31:0] status;
	logic take;

	assign take = hsel && hready && (htrans == HTRANS_NONSEQ);

	always_comb begin
		status = '0;
		status[ST_SERIAL_BIT] = serial_mode;
		status[ST_PD_BIT] = pd_eff;
		status[ST_TWOS_BIT] = twos_eff;
		status[ST_PHASE_BIT] = phase_q;
		status[ST_BUSY_BIT] = ser_busy;
		status[ST_PAIR_BIT] = pair_q;
	end

	always_comb begin
		wr_pend_d = 1'b0;
		wr_addr_d = wr_addr_q;
		rdata_d = rdata_q;
		ctrl_d = ctrl_q;
		if (wr_pend_q && wr_addr_q == ADDR_CTRL) begin
			ctrl_d = hwdata;
		end
		if (take) begin
			wr_pend_d = hwrite;
			wr_addr_d = haddr[ADDR_W-1:0];
			rdata_d = '0;
			if (!hwrite) begin
				case (haddr[ADDR_W-1:0])
					ADDR_CTRL: rdata_d = ctrl_q;
					ADDR_STATUS: rdata_d = status;
					ADDR_CODE_A: rdata_d = {24'h000000, code_a_q};
					ADDR_CODE_B: rdata_d = {24'h000000, code_b_q};
					ADDR_SER_CFG: rdata_d = {24'h000000, ser_cfg};
					default: rdata_d = '0;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
			rdata_q <= '0;
			ctrl_q <= CTRL_RESET;
		end else if (clk_en) begin
			wr_pend_q <= wr_pend_d;
			wr_addr_q <= wr_addr_d;
			rdata_q <= rdata_d;
			ctrl_q <= ctrl_d;
		end
	end

	// stalling while frozen keeps the master from losing a transfer
	assign hreadyout = clk_en;
	assign hresp = 1'b0;
	assign hrdata = rdata_q;

endmodule
